//--- logic/lane_conditioning_config_bank.sv
`timescale 1ns/1ps
// How it works
// - idle override selects mute bit, else auto idle
// - mute bit one mutes output, zero keeps on
// - mode 00 high impedance, 11 fixed 50 ohm
// - mode 01 tries every 12 ms, 50 times
// - mode 10 tries every 12 ms until found
// - modes 01 and 10: termination high impedance until found, then 50
// - written detect mode beats the mode pin
// - boost level eight bits, resets to 2F
// - swing bit 7 enables short protection; reset AD
// - rate bit 6: one gen1/2, zero gen3, overrides pin
// - swing code 000..110 maps 0.7..1.3 V
// - status bit 7 shows far end found
// - bits 6:5 show detected rate in auto
// - emphasis code three bits, default 010
// - assert threshold bits 3:2 override pin, default 00
// - deassert threshold bits 1:0 override pin, default 00
// - force off bit 2 forces detect inactive
// - force on bit 1 forces detect active
// - swing code 111 selects 1.4 V
module lane_conditioning_config_bank #(
	parameter int unsigned DETECT_CYCLES = lane_cfg_pkg::DETECT_PERIOD_CYCLES
) (
	// clock and reset
	input  wire logic       CLK_SYS_I,
	input  wire logic       SYS_RST_I,
	// register port
	input  wire logic [7:0] REG_ADDR_I,
	input  wire logic [7:0] REG_WDATA_I,
	input  wire logic       REG_WR_I,
	input  wire logic       REG_RD_I,
	output logic      [7:0] REG_RDATA_O,
	output logic            REG_ACK_O,
	// configuration pins
	input  wire logic [1:0] RECEIVER_DETECT_MODE_PIN_I,
	input  wire logic [1:0] RATE_MODE_PIN_I,
	input  wire logic [1:0] SQUELCH_THRESHOLD_PIN_I,
	// analog status
	input  wire logic       FAR_END_SEEN_I,
	input  wire logic [1:0] RATE_SEEN_I,
	input  wire logic       IDLE_SEEN_I,
	input  wire logic       LANE_B0_SIGNAL_I,
	// lane a2 controls
	output logic            LANE_MUTE_O,
	output logic            TERM_50_O,
	output logic            DETECT_ATTEMPT_O,
	output logic      [7:0] INPUT_BOOST_LEVEL_O,
	output logic      [2:0] OUTPUT_SWING_CODE_O,
	output logic            SHORT_PROT_EN_O,
	output logic            RATE_GEN12_O,
	output logic      [2:0] EMPHASIS_CODE_O,
	output logic      [1:0] SQ_ASSERT_CODE_O,
	output logic      [1:0] SQ_DEASSERT_CODE_O,
	// lane b0
	output logic            LANE_B0_DETECT_O
);
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction

	lane_cfg_pkg::reg_req_t req;
	lane_cfg_pkg::pin_bus_t pins;
	logic [lane_cfg_pkg::SYNC_W-1:0] raw_pins;
	logic [lane_cfg_pkg::SYNC_W-1:0] sync1;
	logic [lane_cfg_pkg::SYNC_W-1:0] sync2;
	logic [lane_cfg_pkg::SYNC_W-1:0] sync3;
	logic [lane_cfg_pkg::SYNC_W-1:0] settled;

	logic [7:0] idle_ctrl;
	logic [7:0] boost;
	logic [7:0] swing;
	logic [2:0] emphasis;
	logic [3:0] threshold;
	logic [1:0] b0_force;
	logic       receiver_detect_mode_written;
	logic       rate_written;
	logic       thr_written;
	logic [lane_cfg_pkg::DIV_W-1:0] div_cnt;
	logic       tick;
	logic       found;

	assign req = '{addr: REG_ADDR_I, wdata: REG_WDATA_I, wr: REG_WR_I, rd: REG_RD_I};
	assign raw_pins = {RECEIVER_DETECT_MODE_PIN_I, RATE_MODE_PIN_I, SQUELCH_THRESHOLD_PIN_I,
		FAR_END_SEEN_I, RATE_SEEN_I, IDLE_SEEN_I, LANE_B0_SIGNAL_I};
	assign pins = settled;

	// three stages; a level is taken only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < lane_cfg_pkg::SYNC_W; g++) begin : g_sync
			always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
				if (SYS_RST_I) begin
					sync1[g]   <= 1'b0;
					sync2[g]   <= 1'b0;
					sync3[g]   <= 1'b0;
					settled[g] <= 1'b0;
				end else begin
					sync1[g] <= raw_pins[g];
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
					if (sync2[g] == sync3[g]) begin
						settled[g] <= sync3[g];
					end
				end
			end
		end
	endgenerate

	// write decode
	wire wr_idle  = req.wr && hit(req.addr, lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL);
	wire wr_boost = req.wr && hit(req.addr, lane_cfg_pkg::ADDR_INPUT_BOOST);
	wire wr_swing = req.wr && hit(req.addr, lane_cfg_pkg::ADDR_OUTPUT_SWING);
	wire wr_emph  = req.wr && hit(req.addr, lane_cfg_pkg::ADDR_EMPHASIS_STATUS);
	wire wr_thr   = req.wr && hit(req.addr, lane_cfg_pkg::ADDR_IDLE_THRESHOLD);
	wire wr_force = req.wr && hit(req.addr, lane_cfg_pkg::ADDR_B0_DETECT_FORCE);

	// reserved bits are dropped on write so they always read zero
	wire [7:0] idle_wmask = 8'h3C;

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			idle_ctrl <= lane_cfg_pkg::RST_IDLE_DETECT_CTRL;
			boost     <= lane_cfg_pkg::RST_INPUT_BOOST;
			swing     <= lane_cfg_pkg::RST_OUTPUT_SWING;
			emphasis  <= lane_cfg_pkg::RST_EMPHASIS_CODE;
			threshold <= lane_cfg_pkg::RST_IDLE_THRESHOLD;
			b0_force  <= lane_cfg_pkg::RST_B0_DETECT_FORCE;
		end else begin
			if (wr_idle)  idle_ctrl <= req.wdata & idle_wmask;
			if (wr_boost) boost <= req.wdata;
			// bits 5:3 kept as written; host is expected to write 101 there
			if (wr_swing) swing <= req.wdata;
			if (wr_emph)  emphasis <= req.wdata[2:0];
			if (wr_thr)   threshold <= req.wdata[3:0];
			if (wr_force) b0_force <= req.wdata[lane_cfg_pkg::FORCE_OFF_BIT:lane_cfg_pkg::FORCE_ON_BIT];
		end
	end

	// pin settings hold until software first writes the owning register
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			receiver_detect_mode_written <= 1'b0;
			rate_written  <= 1'b0;
			thr_written   <= 1'b0;
		end else begin
			if (wr_idle)  receiver_detect_mode_written <= 1'b1;
			if (wr_swing) rate_written <= 1'b1;
			if (wr_thr)   thr_written <= 1'b1;
		end
	end

	// effective settings
	wire [1:0] reg_receiver_detect_mode = idle_ctrl[lane_cfg_pkg::RECEIVER_DETECT_MODE_LSB +: 2];
	wire [1:0] eff_receiver_detect_mode = receiver_detect_mode_written ? reg_receiver_detect_mode : pins.receiver_detect_mode_pin;
	wire       rate_auto = (pins.rate_pin == lane_cfg_pkg::RATE_PIN_AUTO);
	wire       pin_gen12 = rate_auto ? (pins.rate_seen != lane_cfg_pkg::RATE_DET_GEN3)
		: (pins.rate_pin == lane_cfg_pkg::RATE_PIN_GEN12);
	wire [1:0] rate_result = rate_auto ? pins.rate_seen : 2'h0;
	wire       idle_ovr  = idle_ctrl[lane_cfg_pkg::IDLE_OVR_BIT];
	wire       mute_sel  = idle_ctrl[lane_cfg_pkg::MUTE_SEL_BIT];
	wire       next_mute = idle_ovr ? mute_sel : pins.idle_seen;
	wire       force_off = b0_force[1];
	wire       force_on  = b0_force[0];
	// off wins if both force bits are set
	wire       next_b0   = force_off ? 1'b0 : (force_on ? 1'b1 : pins.b0_signal);

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			LANE_MUTE_O      <= 1'b0;
			LANE_B0_DETECT_O <= 1'b0;
		end else begin
			LANE_MUTE_O      <= next_mute;
			LANE_B0_DETECT_O <= next_b0;
		end
	end

	// config fields come straight from register flops; rate and squelch codes follow the pins until their register is written
	assign INPUT_BOOST_LEVEL_O = boost;
	// all eight codes pass through, 000 lowest and 111 highest swing
	assign OUTPUT_SWING_CODE_O = swing[lane_cfg_pkg::SWING_LSB +: 3];
	assign SHORT_PROT_EN_O     = swing[lane_cfg_pkg::SHORT_PROT_BIT];
	assign RATE_GEN12_O        = rate_written ? swing[lane_cfg_pkg::RATE_SEL_BIT] : pin_gen12;
	assign EMPHASIS_CODE_O     = emphasis;
	// pin threshold code applies to both levels until software takes over
	assign SQ_ASSERT_CODE_O    = thr_written ? threshold[lane_cfg_pkg::SQ_ASSERT_LSB +: 2]
		: pins.thr_pin;
	assign SQ_DEASSERT_CODE_O  = thr_written ? threshold[lane_cfg_pkg::SQ_DEASSERT_LSB +: 2]
		: pins.thr_pin;

	// 12 ms beat for the detect sequencer
	wire div_wrap = (div_cnt == lane_cfg_pkg::DIV_W'(DETECT_CYCLES - 1));

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			div_cnt <= '0;
			tick    <= 1'b0;
		end else begin
			div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
			tick    <= div_wrap;
		end
	end

	rx_detect_seq u_rx_detect_seq (
		.clk_i     (CLK_SYS_I),
		.rst_i     (SYS_RST_I),
		.tick_i    (tick),
		.mode_i    (eff_receiver_detect_mode),
		.far_end_i (pins.far_end),
		.term_50_o (TERM_50_O),
		.found_o   (found),
		.attempt_o (DETECT_ATTEMPT_O)
	);

	// read mux; unmapped and reserved offsets read zero
	wire [7:0] rd_emph = {found, rate_result, 2'b00, emphasis};
	wire [7:0] rd_value =
		hit(req.addr, lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL) ? idle_ctrl :
		hit(req.addr, lane_cfg_pkg::ADDR_INPUT_BOOST)      ? boost :
		hit(req.addr, lane_cfg_pkg::ADDR_OUTPUT_SWING)     ? swing :
		hit(req.addr, lane_cfg_pkg::ADDR_EMPHASIS_STATUS)  ? rd_emph :
		hit(req.addr, lane_cfg_pkg::ADDR_IDLE_THRESHOLD)   ? {4'h0, threshold} :
		hit(req.addr, lane_cfg_pkg::ADDR_B0_DETECT_FORCE)  ? {5'h00, b0_force, 1'b0} :
		8'h00;

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			REG_RDATA_O <= 8'h00;
			REG_ACK_O   <= 1'b0;
		end else begin
			REG_ACK_O <= req.rd || req.wr;
			if (req.rd) begin
				REG_RDATA_O <= rd_value;
			end
		end
	end

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_write(logic [7:0] a);
		req.wr && !req.rd && (req.addr == a);
	endsequence

	sequence s_read(logic [7:0] a);
		req.rd && !req.wr && (req.addr == a);
	endsequence

	property p_mute_override;
		idle_ovr |=> (LANE_MUTE_O == $past(mute_sel));
	endproperty
	a_mute_override: assert property (p_mute_override) else $error("mute not from select");

	property p_mute_auto;
		!idle_ovr |=> (LANE_MUTE_O == $past(pins.idle_seen));
	endproperty
	a_mute_auto: assert property (p_mute_auto) else $error("auto idle not followed");

	property p_boost_rw;
		// one idle cycle between write and read, as a strobe-per-access host leaves it
		s_write(lane_cfg_pkg::ADDR_INPUT_BOOST) ##1 !req.wr
			##1 s_read(lane_cfg_pkg::ADDR_INPUT_BOOST)
			|=> REG_ACK_O && (REG_RDATA_O == $past(INPUT_BOOST_LEVEL_O))
			&& (REG_RDATA_O == $past(req.wdata, 3));
	endproperty
	a_boost_rw: assert property (p_boost_rw) else $error("boost readback wrong");

	property p_gap_zero;
		s_read(lane_cfg_pkg::ADDR_RESERVED_GAP) |=> REG_ACK_O && (REG_RDATA_O == 8'h00);
	endproperty
	a_gap_zero: assert property (p_gap_zero) else $error("reserved gap not zero");

	property p_force_off;
		force_off |=> !LANE_B0_DETECT_O;
	endproperty
	a_force_off: assert property (p_force_off) else $error("force off ignored");

	property p_force_on;
		!force_off && force_on |=> LANE_B0_DETECT_O;
	endproperty
	a_force_on: assert property (p_force_on) else $error("force on ignored");

	property p_receiver_detect_mode_precedence;
		s_write(lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL) |=> (eff_receiver_detect_mode == $past(req.wdata[3:2]));
	endproperty
	a_receiver_detect_mode_precedence: assert property (p_receiver_detect_mode_precedence) else $error("pin beat register");

	property p_rate_override;
		s_write(lane_cfg_pkg::ADDR_OUTPUT_SWING) |=> (RATE_GEN12_O == $past(req.wdata[6]))
			&& (SHORT_PROT_EN_O == $past(req.wdata[7]));
	endproperty
	a_rate_override: assert property (p_rate_override) else $error("rate select not applied");

	property p_tick_single;
		tick |=> !tick;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("beat longer than a cycle");

	property p_found_status;
		s_read(lane_cfg_pkg::ADDR_EMPHASIS_STATUS) |=> (REG_RDATA_O[7] == $past(found))
			&& (REG_RDATA_O[4:3] == 2'b00);
	endproperty
	a_found_status: assert property (p_found_status) else $error("status bit wrong");

endmodule // lane_conditioning_config_bank

//--- pkg/lane_cfg_pkg.sv
package lane_cfg_pkg;

	// register offsets
	localparam logic [7:0] ADDR_IDLE_DETECT_CTRL = 8'h39;
	localparam logic [7:0] ADDR_INPUT_BOOST      = 8'h3A;
	localparam logic [7:0] ADDR_OUTPUT_SWING     = 8'h3B;
	localparam logic [7:0] ADDR_EMPHASIS_STATUS  = 8'h3C;
	localparam logic [7:0] ADDR_IDLE_THRESHOLD   = 8'h3D;
	localparam logic [7:0] ADDR_RESERVED_GAP     = 8'h3E;
	localparam logic [7:0] ADDR_B0_DETECT_FORCE  = 8'h3F;

	// reset values
	localparam logic [7:0] RST_IDLE_DETECT_CTRL  = 8'h00;
	localparam logic [7:0] RST_INPUT_BOOST       = 8'h2F;
	localparam logic [7:0] RST_OUTPUT_SWING      = 8'hAD;
	localparam logic [2:0] RST_EMPHASIS_CODE     = 3'h2;
	localparam logic [3:0] RST_IDLE_THRESHOLD    = 4'h0;
	localparam logic [1:0] RST_B0_DETECT_FORCE   = 2'h0;

	// field positions
	localparam int IDLE_OVR_BIT      = 5;
	localparam int MUTE_SEL_BIT      = 4;
	localparam int RECEIVER_DETECT_MODE_LSB         = 2;
	localparam int SHORT_PROT_BIT    = 7;
	localparam int RATE_SEL_BIT      = 6;
	localparam int SWING_LSB         = 0;
	localparam int SQ_ASSERT_LSB     = 2;
	localparam int SQ_DEASSERT_LSB   = 0;
	localparam int FORCE_OFF_BIT     = 2;
	localparam int FORCE_ON_BIT      = 1;

	// receiver detect modes
	localparam logic [1:0] RECEIVER_DETECT_MODE_HIGHZ   = 2'h0;
	localparam logic [1:0] RECEIVER_DETECT_MODE_LIMITED = 2'h1;
	localparam logic [1:0] RECEIVER_DETECT_MODE_ENDLESS = 2'h2;
	localparam logic [1:0] RECEIVER_DETECT_MODE_FIXED50 = 2'h3;

	// rate pin codes and the detected gen3 rate code
	localparam logic [1:0] RATE_PIN_GEN3  = 2'h0;
	localparam logic [1:0] RATE_PIN_GEN12 = 2'h1;
	localparam logic [1:0] RATE_PIN_AUTO  = 2'h2;
	localparam logic [1:0] RATE_DET_GEN3  = 2'h3;

	// timing
	localparam int unsigned CLK_HZ               = 10_000_000;
	localparam int unsigned DETECT_PERIOD_MS     = 12;
	localparam int unsigned DETECT_PERIOD_CYCLES = DETECT_PERIOD_MS * (CLK_HZ / 1000);
	localparam int          DIV_W                = 17;
	localparam logic [5:0]  ATTEMPT_LIMIT        = 6'd50;

	// synchroniser width: receiver_detect_mode pin 2, rate pin 2, threshold pin 2,
	// far end 1, rate seen 2, idle 1, lane b0 signal 1
	localparam int SYNC_W = 11;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic [1:0] receiver_detect_mode_pin;
		logic [1:0] rate_pin;
		logic [1:0] thr_pin;
		logic       far_end;
		logic [1:0] rate_seen;
		logic       idle_seen;
		logic       b0_signal;
	} pin_bus_t;

	typedef enum logic [4:0] {
		S_HIGHZ   = 5'b00001,
		S_SEARCH  = 5'b00010,
		S_GAVE_UP = 5'b00100,
		S_LINKED  = 5'b01000,
		S_FIXED   = 5'b10000
	} seq_state_t;

endpackage

//--- logic/rx_detect_seq.sv
`timescale 1ns/1ps
module rx_detect_seq (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic       tick_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       far_end_i,
	// status
	output logic            term_50_o,
	output logic            found_o,
	output logic            attempt_o
);
	lane_cfg_pkg::seq_state_t state;
	lane_cfg_pkg::seq_state_t next_state;
	lane_cfg_pkg::seq_state_t entry_state;
	logic [1:0] mode_q;
	logic [5:0] attempts;
	wire        mode_changed = (mode_i != mode_q);
	wire        in_search    = (state == lane_cfg_pkg::S_SEARCH);
	wire        limit_hit    = (mode_i == lane_cfg_pkg::RECEIVER_DETECT_MODE_LIMITED)
		&& (attempts == lane_cfg_pkg::ATTEMPT_LIMIT);

	always_comb begin
		unique case (mode_i)
			lane_cfg_pkg::RECEIVER_DETECT_MODE_HIGHZ:   entry_state = lane_cfg_pkg::S_HIGHZ;
			lane_cfg_pkg::RECEIVER_DETECT_MODE_FIXED50: entry_state = lane_cfg_pkg::S_FIXED;
			default:                     entry_state = lane_cfg_pkg::S_SEARCH;
		endcase
	end

	always_comb begin
		next_state = state;
		if (mode_changed) begin
			next_state = entry_state;
		end else if (in_search && far_end_i) begin
			next_state = lane_cfg_pkg::S_LINKED;
		end else if (in_search && limit_hit) begin
			next_state = lane_cfg_pkg::S_GAVE_UP;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state     <= lane_cfg_pkg::S_HIGHZ;
			mode_q    <= lane_cfg_pkg::RECEIVER_DETECT_MODE_HIGHZ;
			attempts  <= 6'h00;
			attempt_o <= 1'b0;
		end else begin
			state     <= next_state;
			mode_q    <= mode_i;
			// attempts only on the 12 ms beat while still searching
			attempt_o <= in_search && !mode_changed && !far_end_i && !limit_hit && tick_i;
			if (mode_changed) begin
				attempts <= 6'h00;
			end else if (in_search && tick_i && !limit_hit) begin
				attempts <= attempts + 6'h01;
			end
		end
	end

	// high impedance everywhere except fixed and after a find
	assign term_50_o = (state == lane_cfg_pkg::S_LINKED) || (state == lane_cfg_pkg::S_FIXED);
	assign found_o   = (state == lane_cfg_pkg::S_LINKED);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_searching_quiet;
		in_search && !mode_changed && !far_end_i;
	endsequence

	property p_highz_mode;
		(mode_i == lane_cfg_pkg::RECEIVER_DETECT_MODE_HIGHZ) && !mode_changed |-> !term_50_o;
	endproperty
	a_highz_mode: assert property (p_highz_mode) else $error("term on in high-z mode");

	property p_fixed_mode;
		(mode_i == lane_cfg_pkg::RECEIVER_DETECT_MODE_FIXED50) |=> term_50_o;
	endproperty
	a_fixed_mode: assert property (p_fixed_mode) else $error("fixed mode not 50 ohm");

	property p_found_switch;
		s_searching_quiet ##0 (!term_50_o && !limit_hit) ##1 (far_end_i && !mode_changed)
			|=> term_50_o;
	endproperty
	a_found_switch: assert property (p_found_switch) else $error("no 50 ohm after find");

	property p_limit_stop;
		in_search && limit_hit && !mode_changed && !far_end_i
			|=> (state == lane_cfg_pkg::S_GAVE_UP) && !attempt_o;
	endproperty
	a_limit_stop: assert property (p_limit_stop) else $error("search did not stop");

	property p_endless;
		(s_searching_quiet and (mode_i == lane_cfg_pkg::RECEIVER_DETECT_MODE_ENDLESS))
			|=> in_search || mode_changed;
	endproperty
	a_endless: assert property (p_endless) else $error("endless search stopped");

endmodule // rx_detect_seq

//--- dv/far_end_model.sv
`timescale 1ns/1ps
module far_end_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// lane side
	input  wire logic       attempt_i,
	input  wire logic [7:0] find_at_i,
	output logic            present_o
);
	logic [7:0] seen;

	// zero command means no receiver; the count clears so the next run starts fresh
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			seen <= 8'h00;
		end else if (find_at_i == 8'h00) begin
			seen <= 8'h00;
		end else if (attempt_i && seen != 8'hFF) begin
			seen <= seen + 8'h01;
		end
	end

	// receiver appears only on the commanded probe, never earlier
	assign present_o = (find_at_i != 8'h00) && (seen >= find_at_i);
endmodule // far_end_model

//--- dv/lane_conditioning_config_bank_test.sv
`timescale 1ns/1ps
module lane_conditioning_config_bank_test;
	// short beat keeps the 50-attempt run brief
	localparam int unsigned DET = 20;
	logic       clk       = 1'b0;
	logic       rst       = 1'b1;
	logic [7:0] addr      = 8'h00;
	logic [7:0] wdata     = 8'h00;
	logic       wr        = 1'b0;
	logic       rd        = 1'b0;
	logic [1:0] det_pin   = 2'h3;
	logic [1:0] rate_pin  = 2'h1;
	logic [1:0] thr_pin   = 2'h2;
	logic [1:0] rate_seen = 2'h0;
	logic       idle_seen = 1'b0;
	logic       b0_sig    = 1'b0;
	logic [7:0] find_at   = 8'h00;
	logic       far_end, ack, mute, term, attempt, prot, gen12, b0_det;
	logic [7:0] rdata, boost, d;
	logic [2:0] swing, emph;
	logic [1:0] sq_a, sq_d;
	int         mismatches  = 0;
	int         checks_done = 0;
	int         cycles      = 0;
	int         n;
	logic [7:0] rst_exp [7] = '{8'h00, 8'h2F, 8'hAD, 8'h02, 8'h00, 8'h00, 8'h00};
	logic [9:0] mt [4] = '{{8'h30, 2'b01}, {8'h20, 2'b10}, {8'h00, 2'b11}, {8'h00, 2'b00}};
	logic [9:0] bt [6] = '{{8'h00, 2'b11}, {8'h04, 2'b10}, {8'h02, 2'b01},
		{8'h06, 2'b00}, {8'hFF, 2'b10}, {8'h00, 2'b00}};

	lane_conditioning_config_bank #(.DETECT_CYCLES(DET)) dut (
		.CLK_SYS_I                 (clk),
		.SYS_RST_I                 (rst),
		.REG_ADDR_I                (addr),
		.REG_WDATA_I               (wdata),
		.REG_WR_I                  (wr),
		.REG_RD_I                  (rd),
		.REG_RDATA_O               (rdata),
		.REG_ACK_O                 (ack),
		.RECEIVER_DETECT_MODE_PIN_I(det_pin),
		.RATE_MODE_PIN_I           (rate_pin),
		.SQUELCH_THRESHOLD_PIN_I   (thr_pin),
		.FAR_END_SEEN_I            (far_end),
		.RATE_SEEN_I               (rate_seen),
		.IDLE_SEEN_I               (idle_seen),
		.LANE_B0_SIGNAL_I          (b0_sig),
		.LANE_MUTE_O               (mute),
		.TERM_50_O                 (term),
		.DETECT_ATTEMPT_O          (attempt),
		.INPUT_BOOST_LEVEL_O       (boost),
		.OUTPUT_SWING_CODE_O       (swing),
		.SHORT_PROT_EN_O           (prot),
		.RATE_GEN12_O              (gen12),
		.EMPHASIS_CODE_O           (emph),
		.SQ_ASSERT_CODE_O          (sq_a),
		.SQ_DEASSERT_CODE_O        (sq_d),
		.LANE_B0_DETECT_O          (b0_det)
	);

	far_end_model far_end_rx (
		.clk_i    (clk),
		.rst_i    (rst),
		.attempt_i(attempt),
		.find_at_i(find_at),
		.present_o(far_end)
	);

	initial begin
		forever #50 clk = ~clk;
	end

	// whole run needs about 2400 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle strobe; ack and read data land one edge later
	task automatic access(input logic [7:0] a, input logic [7:0] v, input logic w);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= w;
		rd    <= ~w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		chk({7'h00, ack}, 8'h01);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		access(a, v, 1'b1);
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		access(a, 8'h00, 1'b0);
		chk(rdata, exp);
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// counts probe pulses; optionally stops once termination switches
	task automatic watch(input int k, input logic stop);
		n = 0;
		repeat (k) begin
			@(posedge clk);
			#1;
			if (attempt === 1'b1) n++;
			if (stop && term === 1'b1) break;
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		cyc(6);
		chk({7'h00, term}, 8'h01);
		chk(boost, 8'h2F);
		chk({5'h00, swing}, 8'h05);
		chk({7'h00, prot}, 8'h01);
		chk({5'h00, emph}, 8'h02);
		chk({4'h0, sq_a, sq_d}, 8'h0A);
		for (int i = 0; i < 7; i++) rd_reg(8'h39 + 8'(i), rst_exp[i]);
		rd_reg(8'h50, 8'h00);
		// register mode beats the pin, which still asks for 50 ohm
		wr_reg(lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL, 8'h00);
		cyc(2);
		chk({7'h00, term}, 8'h00);
		wr_reg(lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL, 8'h04);
		watch(50 * DET + 60, 1'b0);
		chk(8'(n), 8'd50);
		chk({7'h00, term}, 8'h00);
		@(posedge clk);
		find_at <= 8'd55;
		wr_reg(lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL, 8'h08);
		// window closes before the 55th probe, the one the far end answers
		watch(54 * DET, 1'b1);
		chk(8'(n), 8'd54);
		chk({7'h00, term}, 8'h00);
		watch(2 * DET, 1'b1);
		chk(8'(n), 8'd1);
		chk({7'h00, term}, 8'h01);
		rd_reg(lane_cfg_pkg::ADDR_EMPHASIS_STATUS, 8'h82);
		@(posedge clk);
		find_at <= 8'h00;
		wr_reg(lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL, 8'h0C);
		cyc(2);
		chk({7'h00, term}, 8'h01);
		// reserved bits written as ones on purpose to see them dropped
		wr_reg(lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL, 8'hFF);
		rd_reg(lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL, 8'h3C);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			idle_seen <= mt[i][1];
			wr_reg(lane_cfg_pkg::ADDR_IDLE_DETECT_CTRL, mt[i][9:2]);
			cyc(6);
			chk({7'h00, mute}, {7'h00, mt[i][0]});
		end
		for (int i = 0; i < 2; i++) begin
			d = i ? 8'hFF : 8'h00;
			wr_reg(lane_cfg_pkg::ADDR_INPUT_BOOST, d);
			chk(boost, d);
			rd_reg(lane_cfg_pkg::ADDR_INPUT_BOOST, d);
		end
		// rate pin asks for gen1/2, so a zero in bit 6 shows the override
		for (int i = 0; i < 8; i++) begin
			d = {i[0], i[1], 3'b101, i[2:0]};
			wr_reg(lane_cfg_pkg::ADDR_OUTPUT_SWING, d);
			chk({5'h00, swing}, 8'(i));
			chk({7'h00, prot}, {7'h00, i[0]});
			chk({7'h00, gen12}, {7'h00, i[1]});
			rd_reg(lane_cfg_pkg::ADDR_OUTPUT_SWING, d);
		end
		for (int i = 0; i < 8; i++) begin
			wr_reg(lane_cfg_pkg::ADDR_EMPHASIS_STATUS, {5'h1F, i[2:0]});
			chk({5'h00, emph}, 8'(i));
			rd_reg(lane_cfg_pkg::ADDR_EMPHASIS_STATUS, 8'(i));
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			rate_pin  <= 2'h2;
			rate_seen <= i ? 2'h1 : 2'h3;
			cyc(6);
			rd_reg(lane_cfg_pkg::ADDR_EMPHASIS_STATUS, i ? 8'h27 : 8'h67);
		end
		wr_reg(lane_cfg_pkg::ADDR_IDLE_THRESHOLD, 8'hF6);
		chk({4'h0, sq_a, sq_d}, 8'h06);
		rd_reg(lane_cfg_pkg::ADDR_IDLE_THRESHOLD, 8'h06);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			b0_sig <= bt[i][1];
			wr_reg(lane_cfg_pkg::ADDR_B0_DETECT_FORCE, bt[i][9:2]);
			cyc(6);
			chk({7'h00, b0_det}, {7'h00, bt[i][0]});
			rd_reg(lane_cfg_pkg::ADDR_B0_DETECT_FORCE, bt[i][9:2] & 8'h06);
		end
		wr_reg(lane_cfg_pkg::ADDR_RESERVED_GAP, 8'h55);
		rd_reg(lane_cfg_pkg::ADDR_RESERVED_GAP, 8'h00);
		final_report();
	end
endmodule // lane_conditioning_config_bank_test
